// file: src/pef_defines.vh
`ifndef PEF_DEFINES_VH
`define PEF_DEFINES_VH

// Register byte offsets
`define PEF_OFF_FLAGS 12'h000
`define PEF_OFF_MASK 12'h004
`define PEF_OFF_LIVE 12'h008

// Register select codes
`define PEF_SEL_NONE 2'h0
`define PEF_SEL_FLAGS 2'h1
`define PEF_SEL_MASK 2'h2
`define PEF_SEL_LIVE 2'h3

// Flag bit positions
`define PEF_BIT_TIMER_ONE_COUNT_OVF 0
`define PEF_BIT_TIMER_TWO_COUNT_MATCH 1
`define PEF_BIT_CAPCOMP 2
`define PEF_BIT_SYNC_SERIAL 3
`define PEF_BIT_UART_TX 4
`define PEF_FLAG_W 5

// Reset values
`define PEF_RST_FLAGS 5'h00
`define PEF_RST_MASK 5'h00
`define PEF_RST_RDATA 32'h0000_0000

// Sync serial port modes
`define PEF_SSP_OFF 2'h0
`define PEF_SSP_SPI 2'h1
`define PEF_SSP_I2C_SLAVE 2'h2
`define PEF_SSP_I2C_MASTER 2'h3

// Capture/compare unit modes
`define PEF_CCP_OFF 2'h0
`define PEF_CCP_CAPTURE 2'h1
`define PEF_CCP_COMPARE 2'h2
`define PEF_CCP_PWM 2'h3

// AHB encodings
`define PEF_HTRANS_NONSEQ 2'h2
`define PEF_HRESP_OKAY 1'h0

`endif

// file: src/pef_event_flags.v
// Notes on behaviour
// (RULE_01) Bit 4 is high while the transmit buffer is empty, low while it holds data.
// (RULE_02) Bit 3 sets when a serial transfer finishes in SPI or either I2C mode.
// (RULE_03) Software clears bit 3 before leaving its handler; hardware holds it set.
// (RULE_04) In I2C master mode bit 3 sets when a requested START completes.
// (RULE_05) In I2C master mode bit 3 sets when a requested repeated start completes.
// (RULE_06) In I2C master mode bit 3 sets when a requested acknowledge completes.
// (RULE_07) Bit 3 sets on a bus START seen while the own port is idle; the code does this only in I2C master mode.
// (RULE_08) Bit 3 sets on a bus STOP seen while the own port is idle; the code does this only in I2C master mode.
// (RULE_09) In capture mode bit 2 sets on a timer-one capture; sticky.
// (RULE_10) In compare mode bit 2 sets on a timer-one compare match; sticky.
// (RULE_11) Bit 1 sets when timer two equals its period value; sticky.
// (RULE_12) Bit 0 sets when timer one wraps past its maximum; sticky.
//
// Local design decisions: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "pef_defines.vh"

module pef_event_flags #(
  parameter T1_WIDTH = 16,
  parameter T2_WIDTH = 8
) (
  // Clock, reset, clock enable
  input wire hclk,
  input wire hresetn,
  input wire clk_en,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // Serial transmitter
  input wire uart_tx_buffer_empty,
  // Sync serial port
  input wire [1:0] sync_serial_port_mode,
  input wire sync_serial_port_xfer_done,
  input wire sync_serial_port_start_done,
  input wire sync_serial_port_restart_done,
  input wire sync_serial_port_ack_done,
  input wire sync_serial_port_bus_start_seen,
  input wire sync_serial_port_bus_stop_seen,
  input wire sync_serial_port_idle,
  // Capture/compare unit one
  input wire [1:0] capcomp_unit_one_mode,
  input wire capcomp_unit_one_capture_strobe,
  input wire [T1_WIDTH-1:0] capcomp_unit_one_compare_value,
  // Timers
  input wire [T1_WIDTH-1:0] timer_one_count,
  input wire [T2_WIDTH-1:0] timer_two_count,
  input wire [T2_WIDTH-1:0] timer_two_period,
  // Flags and interrupt
  output wire [7:0] peripheral_event_flags_one,
  output wire irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  function [1:0] pef_decode;
    input [31:0] addr;
    begin
      if (addr[11:0] == `PEF_OFF_FLAGS) begin
        pef_decode = `PEF_SEL_FLAGS;
      end else if (addr[11:0] == `PEF_OFF_MASK) begin
        pef_decode = `PEF_SEL_MASK;
      end else if (addr[11:0] == `PEF_OFF_LIVE) begin
        pef_decode = `PEF_SEL_LIVE;
      end else begin
        pef_decode = `PEF_SEL_NONE;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  reg [`PEF_FLAG_W-1:0] flags_reg;
  reg [`PEF_FLAG_W-1:0] flags_next;
  reg [`PEF_FLAG_W-1:0] mask_reg;
  reg [`PEF_FLAG_W-1:0] mask_next;
  reg [T1_WIDTH-1:0] t1_prev_reg;
  reg irq_reg;
  reg [31:0] hrdata_reg;
  reg [31:0] hrdata_next;
  reg hreadyout_reg;
  reg dp_write_reg;
  reg [1:0] dp_sel_reg;

  wire addr_phase;
  wire [1:0] ap_sel;
  wire dp_wr_flags;
  wire dp_wr_mask;
  wire [1:0] match_level;
  wire [1:0] match_rise;
  wire ssp_on;
  wire ssp_master;
  wire ssp_set;
  wire ccp_set;
  wire timer_two_count_set;
  wire timer_one_count_set;
  wire [`PEF_FLAG_W-1:0] sticky_set;
  wire [`PEF_FLAG_W-1:0] w1c_clear;
  wire [7:0] live_status;

  ////////////////////////////////////////////////////////////////////////////
  // Event sources

  assign match_level[0] = (timer_two_count == timer_two_period);
  assign match_level[1] = (timer_one_count == capcomp_unit_one_compare_value);

  // A timer parked on its match for many prescaled cycles sets once
  pef_rise_detect #(
    .WIDTH(2)
  ) u_match_rise (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .level_in(match_level),
    .rise_out(match_rise)
  );

  assign ssp_on = (sync_serial_port_mode != `PEF_SSP_OFF);
  assign ssp_master = (sync_serial_port_mode == `PEF_SSP_I2C_MASTER);

  assign ssp_set = (ssp_on & sync_serial_port_xfer_done) // RULE_02
    | (ssp_master & sync_serial_port_start_done) // RULE_04
    | (ssp_master & sync_serial_port_restart_done) // RULE_05
    | (ssp_master & sync_serial_port_ack_done) // RULE_06
    | (ssp_master & sync_serial_port_idle & sync_serial_port_bus_start_seen) // RULE_07
    | (ssp_master & sync_serial_port_idle & sync_serial_port_bus_stop_seen); // RULE_08

  assign ccp_set =
    ((capcomp_unit_one_mode == `PEF_CCP_CAPTURE) & capcomp_unit_one_capture_strobe) // RULE_09
    | ((capcomp_unit_one_mode == `PEF_CCP_COMPARE) & match_rise[1]); // RULE_10

  assign timer_two_count_set = match_rise[0]; // RULE_11

  // Wrap means the last count was all ones and this one is zero
  assign timer_one_count_set = (&t1_prev_reg) & (timer_one_count == {T1_WIDTH{1'b0}}); // RULE_12

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t1_prev_reg <= {T1_WIDTH{1'b0}};
    end else if (clk_en) begin
      t1_prev_reg <= timer_one_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite address and data phase

  assign addr_phase = hsel & hready & htrans[1];
  assign ap_sel = pef_decode(haddr);
  assign dp_wr_flags = dp_write_reg & (dp_sel_reg == `PEF_SEL_FLAGS);
  assign dp_wr_mask = dp_write_reg & (dp_sel_reg == `PEF_SEL_MASK);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write_reg <= 1'b0;
      dp_sel_reg <= `PEF_SEL_NONE;
      hreadyout_reg <= 1'b1;
    end else if (clk_en) begin
      // Zero wait states, so every data phase ends at its first edge
      hreadyout_reg <= 1'b1;
      if (addr_phase) begin
        dp_write_reg <= hwrite;
        dp_sel_reg <= ap_sel;
      end else begin
        dp_write_reg <= 1'b0;
        dp_sel_reg <= `PEF_SEL_NONE;
      end
    end
  end

  assign live_status = {2'h0, capcomp_unit_one_mode, sync_serial_port_mode,
    sync_serial_port_idle, uart_tx_buffer_empty};

  // Read data is taken at the address-phase edge and held through the data phase
  always @* begin
    hrdata_next = hrdata_reg;
    if (addr_phase && !hwrite) begin
      if (ap_sel == `PEF_SEL_FLAGS) begin
        hrdata_next = {27'h0, flags_reg};
      end else if (ap_sel == `PEF_SEL_MASK) begin
        hrdata_next = {27'h0, mask_reg};
      end else if (ap_sel == `PEF_SEL_LIVE) begin
        hrdata_next = {24'h0, live_status};
      end else begin
        hrdata_next = 32'h0000_0000;
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= `PEF_RST_RDATA;
    end else if (clk_en) begin
      hrdata_reg <= hrdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags, mask, interrupt

  assign sticky_set = {1'b0, ssp_set, ccp_set, timer_two_count_set, timer_one_count_set};
  // Bit 4 follows the buffer, so a write of one there does nothing
  assign w1c_clear = dp_wr_flags ? {1'b0, hwdata[3:0]} : {`PEF_FLAG_W{1'b0}};

  always @* begin
    // A set in the same cycle as its clear wins, so no event is lost
    flags_next = (flags_reg & ~w1c_clear) | sticky_set; // RULE_03
    flags_next[`PEF_BIT_UART_TX] = uart_tx_buffer_empty; // RULE_01
    mask_next = mask_reg;
    if (dp_wr_mask) begin
      mask_next = hwdata[`PEF_FLAG_W-1:0];
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_reg <= `PEF_RST_FLAGS;
      mask_reg <= `PEF_RST_MASK;
      irq_reg <= 1'b0;
    end else if (clk_en) begin
      flags_reg <= flags_next; // RULE_09 RULE_10 RULE_11 RULE_12
      mask_reg <= mask_next;
      irq_reg <= |(flags_next & mask_next);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = `PEF_HRESP_OKAY;
  assign peripheral_event_flags_one = {3'h0, flags_reg};
  assign irq = irq_reg;

endmodule // pef_event_flags

`default_nettype wire

// file: src/pef_rise_detect.v
`timescale 1ns/10ps
`default_nettype none

module pef_rise_detect #(
  parameter WIDTH = 2
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  input wire clk_en,
  // Levels in, one-cycle pulses out
  input wire [WIDTH-1:0] level_in,
  output wire [WIDTH-1:0] rise_out
);

  reg [WIDTH-1:0] prev_reg;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_reg <= {WIDTH{1'b0}};
    end else if (clk_en) begin
      prev_reg <= level_in;
    end
  end

  // Held match levels count once, not every cycle they last
  assign rise_out = level_in & ~prev_reg;

endmodule // pef_rise_detect

`default_nettype wire

// file: test/pef_flags_props.sv
`timescale 1ns/10ps
`default_nettype none

module pef_flags_props #(
  parameter T1_WIDTH = 16,
  parameter T2_WIDTH = 8
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  input wire clk_en,
  // Causes
  input wire [31:0] hwdata,
  input wire uart_tx_buffer_empty,
  input wire [1:0] sync_serial_port_mode,
  input wire sync_serial_port_xfer_done,
  input wire sync_serial_port_start_done,
  input wire sync_serial_port_restart_done,
  input wire sync_serial_port_ack_done,
  input wire sync_serial_port_bus_start_seen,
  input wire sync_serial_port_bus_stop_seen,
  input wire sync_serial_port_idle,
  input wire [1:0] capcomp_unit_one_mode,
  input wire capcomp_unit_one_capture_strobe,
  input wire [T1_WIDTH-1:0] timer_one_count,
  input wire [T2_WIDTH-1:0] timer_two_count,
  input wire [T2_WIDTH-1:0] timer_two_period,
  // Results
  input wire [7:0] peripheral_event_flags_one,
  input wire irq
);
  wire [7:0] f = peripheral_event_flags_one;
  wire [1:0] sm = sync_serial_port_mode;
  wire t2eq = timer_two_count == timer_two_period;
  wire mev = sync_serial_port_start_done | sync_serial_port_restart_done |
    sync_serial_port_ack_done | (sync_serial_port_idle &
    (sync_serial_port_bus_start_seen | sync_serial_port_bus_stop_seen));
  default clocking dcb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////
  // Skip the release edge: the copy still shows its reset value there
  tx_flag_a: assert property ($past(hresetn) && $past(clk_en) |->
    f[4] == $past(uart_tx_buffer_empty)) else $error("tx flag lags buffer state");
  // A flag in bits 3:0 may only fall where a one was written to it
  sticky_flags_a: assert property (!(|($past(f[3:0]) & ~f[3:0] & ~$past(hwdata[3:0]))))
    else $error("flag dropped without clear");
  // Edge detectors only advance on enabled cycles, so both edges must be enabled
  t2_match_a: assert property (clk_en && $past(clk_en) && t2eq && !$past(t2eq) |=> f[1])
    else $error("timer two match not flagged");
  t1_wrap_a: assert property ($past(hresetn) && $past(clk_en) && clk_en
    && $past(timer_one_count) == '1 && timer_one_count == '0 |=> f[0])
    else $error("timer one wrap not flagged");
  capture_set_a: assert property (clk_en && capcomp_unit_one_mode == 2'h1
    && capcomp_unit_one_capture_strobe |=> f[2]) else $error("capture not flagged");
  xfer_set_a: assert property (clk_en && sm != 2'h0 && sync_serial_port_xfer_done |=> f[3])
    else $error("transfer not flagged");
  master_event_a: assert property (clk_en && sm == 2'h3 && mev |=> f[3])
    else $error("master event not flagged");
  irq_quiet_a: assert property (f[4:0] == 5'h00 |-> !irq)
    else $error("irq without flag");
endmodule // pef_flags_props

bind pef_event_flags pef_flags_props #(.T1_WIDTH(T1_WIDTH), .T2_WIDTH(T2_WIDTH)) props_i (
  .hclk(hclk),
  .hresetn(hresetn),
  .clk_en(clk_en),
  .hwdata(hwdata),
  .uart_tx_buffer_empty(uart_tx_buffer_empty),
  .sync_serial_port_mode(sync_serial_port_mode),
  .sync_serial_port_xfer_done(sync_serial_port_xfer_done),
  .sync_serial_port_start_done(sync_serial_port_start_done),
  .sync_serial_port_restart_done(sync_serial_port_restart_done),
  .sync_serial_port_ack_done(sync_serial_port_ack_done),
  .sync_serial_port_bus_start_seen(sync_serial_port_bus_start_seen),
  .sync_serial_port_bus_stop_seen(sync_serial_port_bus_stop_seen),
  .sync_serial_port_idle(sync_serial_port_idle),
  .capcomp_unit_one_mode(capcomp_unit_one_mode),
  .capcomp_unit_one_capture_strobe(capcomp_unit_one_capture_strobe),
  .timer_one_count(timer_one_count),
  .timer_two_count(timer_two_count),
  .timer_two_period(timer_two_period),
  .peripheral_event_flags_one(peripheral_event_flags_one),
  .irq(irq)
);

`default_nettype wire

// file: test/test_peripheral_irq_flags_low.sv
`timescale 1ns/10ps
`default_nettype none
`include "pef_defines.vh"

module test_peripheral_irq_flags_low;
  logic hclk = 1'h0, hresetn = 1'h0, clk_en = 1'h1, hsel = 1'h0, hwrite = 1'h0;
  logic tx = 1'h1, idle = 1'h1;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd_data;
  logic [1:0] htrans = 2'h0, sm = 2'h0, cm = 2'h0;
  logic [6:0] p = 7'h00;
  logic [15:0] t1 = 16'h1234, cv = 16'h0000;
  logic [31:0] v;
  logic [7:0] t2 = 8'h00, pr = 8'h80;
  wire [31:0] hrdata;
  wire [7:0] flags;
  wire hreadyout, hresp, irq;
  int err_count = 0, num_checks = 0, cyc = 0, pb = 0;

  pef_event_flags dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .peripheral_event_flags_one(flags),
    .uart_tx_buffer_empty(tx), .sync_serial_port_mode(sm), .sync_serial_port_idle(idle),
    .sync_serial_port_xfer_done(p[0]), .sync_serial_port_start_done(p[1]),
    .sync_serial_port_restart_done(p[2]), .sync_serial_port_ack_done(p[3]),
    .sync_serial_port_bus_start_seen(p[4]), .sync_serial_port_bus_stop_seen(p[5]),
    .capcomp_unit_one_mode(cm), .capcomp_unit_one_capture_strobe(p[6]),
    .capcomp_unit_one_compare_value(cv), .timer_one_count(t1),
    .timer_two_count(t2), .timer_two_period(pr));
  ////////////////////////////////////////////////////////////
  task automatic test_done();
    if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask

  // Flag bits that one pulse on input b should leave, per mode and idle level
  function automatic logic [3:0] exp_pulse(input int b, input logic [1:0] s,
    input logic [1:0] c, input logic id);
    exp_pulse = 4'h0;
    if (b == 0 && s != `PEF_SSP_OFF) exp_pulse = 4'h8;
    if (b >= 1 && b <= 3 && s == `PEF_SSP_I2C_MASTER) exp_pulse = 4'h8;
    if (b >= 4 && b <= 5 && s == `PEF_SSP_I2C_MASTER && id) exp_pulse = 4'h8;
    if (b == 6 && c == `PEF_CCP_CAPTURE) exp_pulse = 4'h4;
  endfunction

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= `PEF_HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd_data = hrdata;
    hwdata <= 32'h0;
  endtask

  // Read late on purpose, so only a held flag can pass
  task automatic ck_flags(input logic [3:0] e);
    xfer(1'h0, `PEF_OFF_FLAGS, 32'h0);
    chk("flags", rd_data[3:0], e);
    chk("irq set", irq, |e);
    xfer(1'h1, `PEF_OFF_FLAGS, 32'hf);
    xfer(1'h0, `PEF_OFF_FLAGS, 32'h0);
    chk("flags clr", rd_data[3:0], 4'h0);
    chk("irq clr", irq, 1'h0);
  endtask

  task automatic pulse(input int b, input logic [1:0] s, input logic [1:0] c);
    @(posedge hclk);
    sm <= s;
    cm <= c;
    p[b] <= 1'h1;
    @(posedge hclk);
    p <= 7'h00;
  endtask

  initial forever #12.5 hclk = ~hclk;

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      test_done();
    end
  end

  initial begin
    v = $urandom(57755);
    repeat (8) @(posedge hclk);
    hresetn <= 1'h1;
    xfer(1'h0, `PEF_OFF_MASK, 32'h0);
    chk("mask rst", rd_data, 32'h0);
    xfer(1'h0, `PEF_OFF_FLAGS, 32'h0);
    chk("flags rst", rd_data, 32'h10);
    xfer(1'h1, 12'h00c, 32'hffff_ffff);
    xfer(1'h0, 12'h00c, 32'h0);
    chk("unmapped", rd_data, 32'h0);
    chk("hresp", hresp, `PEF_HRESP_OKAY);
    // Bit 4 masked: it follows a level and would hold irq up
    xfer(1'h1, `PEF_OFF_MASK, 32'hf);
    xfer(1'h0, `PEF_OFF_MASK, 32'h0);
    chk("mask", rd_data, 32'hf);
    repeat (4) begin
      v = $urandom;
      tx <= v[0];
      xfer(1'h1, `PEF_OFF_FLAGS, 32'h10);
      xfer(1'h0, `PEF_OFF_FLAGS, 32'h0);
      chk("tx flag", rd_data[4], tx);
    end
    for (int m = 1; m < 4; m++) begin
      pulse(0, m[1:0], 2'h0);
      ck_flags(4'h8);
    end
    for (int b = 1; b < 6; b++) begin
      pulse(b, 2'h3, 2'h0);
      ck_flags(4'h8);
    end
    idle <= 1'h0;
    pulse(4, 2'h3, 2'h0);
    ck_flags(4'h0);
    repeat (24) begin
      v = $urandom;
      pb = v[2:0] % 7;
      idle <= v[8];
      pulse(pb, v[4:3], v[6:5]);
      ck_flags(exp_pulse(pb, v[4:3], v[6:5], v[8]));
    end
    // Frozen by the clock enable, so these pulses must leave no flag
    clk_en <= 1'h0;
    pulse(0, 2'h1, 2'h1);
    pulse(6, 2'h1, 2'h1);
    clk_en <= 1'h1;
    ck_flags(4'h0);
    idle <= 1'h1;
    pulse(0, 2'h0, 2'h0);
    pulse(6, 2'h0, 2'h1);
    ck_flags(4'h4);
    cm <= 2'h2;
    v = $urandom;
    t1 <= v[15:0];
    @(posedge hclk);
    cv <= t1;
    ck_flags(4'h4);
    cm <= 2'h0;
    v = $urandom;
    pr <= v[7:0];
    @(posedge hclk);
    t2 <= v[7:0];
    ck_flags(4'h2);
    t1 <= 16'hffff;
    @(posedge hclk);
    t1 <= 16'h0000;
    ck_flags(4'h1);
    test_done();
  end
endmodule // test_peripheral_irq_flags_low

`default_nettype wire
